/* hw/rtc_ctrl.sv */
// Alarm, countdown, supply, conversion and event logic of the clock control block.
`timescale 1ns/1ps
module rtc_ctrl #(
  parameter int CONV_CYCLES = rtc_ctrl_pkg::CONV_CYCLES,
  parameter int INTERVAL_BITS = 3
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic coreEn,
  input wire logic secondTick,
  input wire logic [3:0] countdownTicks,
  input wire rtc_ctrl_pkg::rtc_time_type timeNow,
  input wire logic vccBelowThreshold,
  input wire logic vccBelowBackup,
  input wire logic linkClk,
  input wire logic regReq,
  input wire rtc_ctrl_pkg::rtc_req_type regCmd,
  output logic regBusy,
  output logic regAck,
  output logic [7:0] regRdata,
  output logic intOut_n,
  output logic useBackup,
  output logic chargerOn,
  output logic [1:0] supplyThresholdSelect,
  output logic oscStop,
  output logic convStart,
  output logic softResetPulse
);
  typedef enum logic [1:0] {
    CD_IDLE = 2'b01,
    CD_COUNT = 2'b10
  } rtc_cd_state_type;

  // Link domain: capture a request and hand it across with a toggle.
  logic [1:0] linkRstSync_reg;
  logic linkRst_n;
  rtc_ctrl_pkg::rtc_req_type heldCmd_reg;
  logic reqToggle_reg;
  logic ackToggle_reg;
  logic ackSync1_reg;
  logic ackSync2_reg;
  logic ackSeen_reg;
  logic [7:0] answer_reg;

  // The reset reaching the link side is re-timed so its release is clean there.
  always_ff @(posedge linkClk) begin
    linkRstSync_reg <= {linkRstSync_reg[0], reset_n};
  end
  assign linkRst_n = linkRstSync_reg[1];

  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      heldCmd_reg <= '0;
      reqToggle_reg <= 1'b0;
      regBusy <= 1'b0;
    end else if (regReq && !regBusy) begin
      heldCmd_reg <= regCmd;
      reqToggle_reg <= ~reqToggle_reg;
      regBusy <= 1'b1;
    end else if (ackSync2_reg != ackSeen_reg) begin
      regBusy <= 1'b0;
    end
  end

  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      ackSync1_reg <= 1'b0;
      ackSync2_reg <= 1'b0;
      ackSeen_reg <= 1'b0;
      regAck <= 1'b0;
      regRdata <= 8'h00;
    end else begin
      ackSync1_reg <= ackToggle_reg;
      ackSync2_reg <= ackSync1_reg;
      ackSeen_reg <= ackSync2_reg;
      regAck <= ackSync2_reg != ackSeen_reg;
      if (ackSync2_reg != ackSeen_reg) begin
        regRdata <= answer_reg;
      end
    end
  end

  // Core domain: request toggle and analog comparator levels are synchronised.
  logic reqSync1_reg;
  logic reqSync2_reg;
  logic reqSeen_reg;
  logic [1:0] belowThrSync_reg;
  logic [1:0] belowBakSync_reg;
  logic belowThrLast_reg;
  logic access;
  logic doWrite;
  logic doRead;

  always_ff @(posedge core_clk) begin
    reqSync1_reg <= reqToggle_reg;
    reqSync2_reg <= reqSync1_reg;
    belowThrSync_reg <= {belowThrSync_reg[0], vccBelowThreshold};
    belowBakSync_reg <= {belowBakSync_reg[0], vccBelowBackup};
  end

  assign access = coreEn && (reqSync2_reg != reqSeen_reg);
  assign doWrite = access && heldCmd_reg.write;
  assign doRead = access && !heldCmd_reg.write;

  // Registers.
  logic [7:0] eventFlags_reg;
  logic [7:0] irqEnable_reg;
  logic [7:0] retentionCfg_reg;
  logic [7:0] countdownCfg_reg;
  logic [7:0] countdownStart_reg;
  logic [7:0] countdownNow_reg;
  logic [7:0] supplyMgmt_reg;
  logic [7:0] chargerCfg_reg;
  logic [7:0] thermalCfg_reg;
  logic [7:0] alarmReg_reg [rtc_ctrl_pkg::ALARM_BYTES];
  logic [7:0] readValue;
  logic [7:0] setFlags;
  logic retention;
  logic softReset;

  assign retention = retentionCfg_reg[rtc_ctrl_pkg::BIT_RETENTION];
  assign softReset = doWrite && heldCmd_reg.addr == rtc_ctrl_pkg::ADDR_SOFT_RESET
    && heldCmd_reg.wdata[rtc_ctrl_pkg::BIT_SOFT_RESET];

  always_comb begin
    readValue = 8'h00;
    case (heldCmd_reg.addr)
      rtc_ctrl_pkg::ADDR_EVENT_FLAGS: readValue = eventFlags_reg;
      rtc_ctrl_pkg::ADDR_IRQ_ENABLE: readValue = irqEnable_reg;
      rtc_ctrl_pkg::ADDR_RETENTION_CFG: readValue = retentionCfg_reg;
      rtc_ctrl_pkg::ADDR_COUNTDOWN_CFG: readValue = countdownCfg_reg;
      rtc_ctrl_pkg::ADDR_COUNTDOWN_NOW: readValue = countdownNow_reg;
      rtc_ctrl_pkg::ADDR_COUNTDOWN_START: readValue = countdownStart_reg;
      rtc_ctrl_pkg::ADDR_SUPPLY_MGMT: readValue = supplyMgmt_reg;
      rtc_ctrl_pkg::ADDR_CHARGER_CFG: readValue = chargerCfg_reg;
      rtc_ctrl_pkg::ADDR_THERMAL_CFG: readValue = thermalCfg_reg;
      default: begin
        if (heldCmd_reg.addr >= rtc_ctrl_pkg::ADDR_ALARM_FIRST
            && heldCmd_reg.addr <= rtc_ctrl_pkg::ADDR_ALARM_LAST) begin
          readValue = alarmReg_reg[4'(heldCmd_reg.addr - rtc_ctrl_pkg::ADDR_ALARM_FIRST)];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reqSeen_reg <= 1'b0;
      ackToggle_reg <= 1'b0;
      answer_reg <= 8'h00;
    end else if (access) begin
      reqSeen_reg <= reqSync2_reg;
      ackToggle_reg <= ~ackToggle_reg;
      answer_reg <= readValue;
    end
  end

  // Control registers; the soft reset returns them to their reset values.
  always_ff @(posedge core_clk) begin
    if (!reset_n || (coreEn && softReset)) begin
      irqEnable_reg <= rtc_ctrl_pkg::IRQ_ENABLE_RESET;
      retentionCfg_reg <= rtc_ctrl_pkg::RETENTION_CFG_RESET;
      countdownCfg_reg <= rtc_ctrl_pkg::COUNTDOWN_CFG_RESET;
      countdownStart_reg <= 8'h00;
      supplyMgmt_reg <= rtc_ctrl_pkg::SUPPLY_MGMT_RESET;
      chargerCfg_reg <= rtc_ctrl_pkg::CHARGER_CFG_RESET;
    end else if (doWrite) begin
      case (heldCmd_reg.addr)
        rtc_ctrl_pkg::ADDR_IRQ_ENABLE: irqEnable_reg <= heldCmd_reg.wdata;
        rtc_ctrl_pkg::ADDR_RETENTION_CFG: retentionCfg_reg <= heldCmd_reg.wdata;
        rtc_ctrl_pkg::ADDR_COUNTDOWN_CFG: countdownCfg_reg <= heldCmd_reg.wdata;
        rtc_ctrl_pkg::ADDR_COUNTDOWN_START: countdownStart_reg <= heldCmd_reg.wdata;
        rtc_ctrl_pkg::ADDR_SUPPLY_MGMT: supplyMgmt_reg <= heldCmd_reg.wdata;
        rtc_ctrl_pkg::ADDR_CHARGER_CFG: chargerCfg_reg <= heldCmd_reg.wdata;
        default: begin
        end
      endcase
    end
  end

  // Alarm compare bytes, one entry per offset.
  generate
    for (genvar i = 0; i < rtc_ctrl_pkg::ALARM_BYTES; i++) begin : g_alarm
      always_ff @(posedge core_clk) begin
        if (!reset_n || (coreEn && softReset)) begin
          alarmReg_reg[i] <= rtc_ctrl_pkg::ALARM_RESET;
        end else if (doWrite
                     && heldCmd_reg.addr == rtc_ctrl_pkg::ADDR_ALARM_FIRST + 8'(i)) begin
          alarmReg_reg[i] <= heldCmd_reg.wdata;
        end
      end
    end
  endgenerate

  // Alarm matching.
  logic [7:0] a1Sec, a1Min, a1Hour, a1Day, a1Month, a1Year, a2Min, a2Hour, a2Day;
  logic a1DayHit, a2DayHit, firstMatch, secondMatch, tickLive;
  assign a1Sec = alarmReg_reg[rtc_ctrl_pkg::A1_SEC];
  assign a1Min = alarmReg_reg[rtc_ctrl_pkg::A1_MIN];
  assign a1Hour = alarmReg_reg[rtc_ctrl_pkg::A1_HOUR];
  assign a1Day = alarmReg_reg[rtc_ctrl_pkg::A1_DAY];
  assign a1Month = alarmReg_reg[rtc_ctrl_pkg::A1_MONTH];
  assign a1Year = alarmReg_reg[rtc_ctrl_pkg::A1_YEAR];
  assign a2Min = alarmReg_reg[rtc_ctrl_pkg::A2_MIN];
  assign a2Hour = alarmReg_reg[rtc_ctrl_pkg::A2_HOUR];
  assign a2Day = alarmReg_reg[rtc_ctrl_pkg::A2_DAY];
  // Select bit clear compares the weekday, set compares the day of month.
  assign a1DayHit = a1Day[rtc_ctrl_pkg::BIT_DAY_SELECT] ? a1Day[5:0] == timeNow.date[5:0]
                    : a1Day[5:0] == timeNow.day[5:0];
  assign a2DayHit = a2Day[rtc_ctrl_pkg::BIT_DAY_SELECT] ? a2Day[5:0] == timeNow.date[5:0]
                    : a2Day[5:0] == timeNow.day[5:0];
  // A set mask drops its field from the compare.
  assign firstMatch =
    (a1Sec[rtc_ctrl_pkg::BIT_MASK] || a1Sec[6:0] == timeNow.sec[6:0])
    && (a1Min[rtc_ctrl_pkg::BIT_MASK] || a1Min[6:0] == timeNow.min[6:0])
    && (a1Hour[rtc_ctrl_pkg::BIT_MASK] || a1Hour[5:0] == timeNow.hour[5:0])
    && (a1Day[rtc_ctrl_pkg::BIT_MASK] || a1DayHit)
    && (a1Month[rtc_ctrl_pkg::BIT_MASK] || a1Month[4:0] == timeNow.month[4:0])
    && (a1Month[rtc_ctrl_pkg::BIT_YEAR_MASK] || a1Year == timeNow.year);
  assign secondMatch = timeNow.sec == 8'h00
    && (a2Min[rtc_ctrl_pkg::BIT_MASK] || a2Min[6:0] == timeNow.min[6:0])
    && (a2Hour[rtc_ctrl_pkg::BIT_MASK] || a2Hour[5:0] == timeNow.hour[5:0])
    && (a2Day[rtc_ctrl_pkg::BIT_MASK] || a2DayHit);
  // Comparing only on the tick keeps a match that lasts a second from refiring.
  assign tickLive = coreEn && secondTick && !retention;

  // Countdown timer.
  rtc_cd_state_type cdState_reg;
  logic cdRun, cdHold, cdTick, cdZeroEvent;
  assign cdRun = countdownCfg_reg[rtc_ctrl_pkg::BIT_COUNTDOWN_RUN];
  assign cdHold = cdRun && countdownCfg_reg[rtc_ctrl_pkg::BIT_COUNTDOWN_HOLD];
  assign cdTick = coreEn && !retention && countdownTicks[countdownCfg_reg[1:0]];
  assign cdZeroEvent = cdState_reg == CD_COUNT && cdRun && cdTick && !cdHold
    && countdownNow_reg == 8'h01;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cdState_reg <= CD_IDLE;
      countdownNow_reg <= 8'h00;
    end else if (coreEn) begin
      case (cdState_reg)
        CD_IDLE: begin
          // A start that is already held waits, so the hold keeps the count as it is.
          if (cdRun && !cdHold && !retention) begin
            countdownNow_reg <= countdownStart_reg;
            cdState_reg <= countdownStart_reg == 8'h00 ? CD_IDLE : CD_COUNT;
          end
        end
        CD_COUNT: begin
          if (!cdRun) begin
            countdownNow_reg <= 8'h00;
            cdState_reg <= CD_IDLE;
          // A run that ended without reload parks at zero instead of wrapping.
          end else if (cdTick && !cdHold && countdownNow_reg != 8'h00) begin
            if (countdownNow_reg == 8'h01) begin
              if (countdownCfg_reg[rtc_ctrl_pkg::BIT_COUNTDOWN_RELOAD]) begin
                countdownNow_reg <= countdownStart_reg;
              end else begin
                countdownNow_reg <= 8'h00;
              end
            end else begin
              countdownNow_reg <= countdownNow_reg - 8'h01;
            end
          end
        end
        default: cdState_reg <= CD_IDLE;
      endcase
    end
  end

  // Temperature conversion control.
  logic [$clog2(CONV_CYCLES + 1)-1:0] convCount_reg;
  logic [(1 << INTERVAL_BITS)-1:0] intervalCount_reg;
  logic singleWrite, convDone, periodicDue;
  assign singleWrite = doWrite && heldCmd_reg.addr == rtc_ctrl_pkg::ADDR_THERMAL_CFG
    && !heldCmd_reg.wdata[rtc_ctrl_pkg::BIT_PERIODIC_CONV]
    && heldCmd_reg.wdata[rtc_ctrl_pkg::BIT_SINGLE_CONV];
  assign convDone = convCount_reg == ($clog2(CONV_CYCLES + 1))'(1);
  assign periodicDue = tickLive && thermalCfg_reg[rtc_ctrl_pkg::BIT_PERIODIC_CONV]
    && intervalCount_reg == 8'((1 << thermalCfg_reg[5:3]) - 1);

  always_ff @(posedge core_clk) begin
    if (!reset_n || (coreEn && softReset)) begin
      thermalCfg_reg <= rtc_ctrl_pkg::THERMAL_CFG_RESET;
      convCount_reg <= '0;
      intervalCount_reg <= '0;
      convStart <= 1'b0;
    end else if (coreEn) begin
      convStart <= singleWrite || periodicDue;
      if (doWrite && heldCmd_reg.addr == rtc_ctrl_pkg::ADDR_THERMAL_CFG) begin
        thermalCfg_reg <= heldCmd_reg.wdata & {1'b1, !heldCmd_reg.wdata[7], 6'h3F};
      end else if (convDone) begin
        thermalCfg_reg[rtc_ctrl_pkg::BIT_SINGLE_CONV] <= 1'b0;
      end
      if (singleWrite) begin
        convCount_reg <= ($clog2(CONV_CYCLES + 1))'(CONV_CYCLES);
      end else if (convCount_reg != '0) begin
        convCount_reg <= convCount_reg - 1'b1;
      end
      if (periodicDue) begin
        intervalCount_reg <= '0;
      end else if (tickLive) begin
        intervalCount_reg <= intervalCount_reg + 1'b1;
      end
    end
  end

  // Supply management outputs and the drop detector.
  logic manualMode, thresholdRaise;
  assign manualMode = supplyMgmt_reg[rtc_ctrl_pkg::BIT_MANUAL_SUPPLY];
  assign thresholdRaise = doWrite && heldCmd_reg.addr == rtc_ctrl_pkg::ADDR_SUPPLY_MGMT
    && heldCmd_reg.wdata[5:4] != supplyMgmt_reg[5:4];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      useBackup <= 1'b0;
      chargerOn <= 1'b0;
      supplyThresholdSelect <= 2'h1;
      oscStop <= 1'b0;
      belowThrLast_reg <= 1'b0;
      softResetPulse <= 1'b0;
    end else if (coreEn) begin
      belowThrLast_reg <= belowThrSync_reg[1];
      supplyThresholdSelect <= supplyMgmt_reg[5:4];
      chargerOn <= chargerCfg_reg[7:4] == rtc_ctrl_pkg::CHARGER_ON_CODE;
      oscStop <= retention || !retentionCfg_reg[rtc_ctrl_pkg::BIT_OSC_ENABLE];
      softResetPulse <= softReset;
      if (retention) begin
        useBackup <= 1'b0;
      end else if (manualMode) begin
        useBackup <= supplyMgmt_reg[rtc_ctrl_pkg::BIT_BACKUP_SOURCE]
          && belowBakSync_reg[1];
      end else begin
        useBackup <= belowThrSync_reg[1] && belowBakSync_reg[1];
      end
    end
  end

  // Event flags: a new event in the read cycle survives the clear.
  always_comb begin
    setFlags = 8'h00;
    setFlags[rtc_ctrl_pkg::FLAG_FIRST_ALARM] = tickLive && firstMatch;
    setFlags[rtc_ctrl_pkg::FLAG_SECOND_ALARM] = tickLive && secondMatch;
    setFlags[rtc_ctrl_pkg::FLAG_COUNTDOWN] = cdZeroEvent;
    setFlags[rtc_ctrl_pkg::FLAG_THERMAL] = convDone;
    setFlags[rtc_ctrl_pkg::FLAG_SUPPLY_DROP] = !manualMode && !retention
      && belowThrSync_reg[1] && (!belowThrLast_reg || thresholdRaise);
    setFlags = setFlags & irqEnable_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      eventFlags_reg <= rtc_ctrl_pkg::EVENT_FLAGS_RESET;
      intOut_n <= 1'b1;
    end else if (coreEn) begin
      if (doRead && heldCmd_reg.addr == rtc_ctrl_pkg::ADDR_EVENT_FLAGS) begin
        eventFlags_reg <= setFlags;
        intOut_n <= setFlags == 8'h00;
      end else begin
        eventFlags_reg <= eventFlags_reg | setFlags;
        intOut_n <= (eventFlags_reg | setFlags) == 8'h00;
      end
    end
  end

  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_cdLastTick;
    cdZeroEvent && countdownCfg_reg[rtc_ctrl_pkg::BIT_COUNTDOWN_RELOAD] && coreEn;
  endsequence
  sequence s_eventRaised;
    coreEn && setFlags != 8'h00;
  endsequence

  property p_flagNeedsEnable;
    coreEn |=> (eventFlags_reg & ~$past(eventFlags_reg) & ~$past(irqEnable_reg)) == 8'h00;
  endproperty
  a_flagNeedsEnable: assert property (p_flagNeedsEnable) else $error("flag set while disabled");
  property p_intFollowsEvent;
    s_eventRaised |=> !intOut_n && eventFlags_reg != 8'h00;
  endproperty
  a_intFollowsEvent: assert property (p_intFollowsEvent) else $error("event lost");
  property p_readClears;
    doRead && heldCmd_reg.addr == rtc_ctrl_pkg::ADDR_EVENT_FLAGS && setFlags == 8'h00
      |=> eventFlags_reg == 8'h00 && intOut_n;
  endproperty
  a_readClears: assert property (p_readClears) else $error("read did not clear");
  property p_reload;
    s_cdLastTick |=> countdownNow_reg == $past(countdownStart_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");
  property p_holdKeeps;
    coreEn && cdHold && cdRun |=> countdownNow_reg == $past(countdownNow_reg);
  endproperty
  a_holdKeeps: assert property (p_holdKeeps) else $error("count moved on hold");
  property p_retentionMain;
    coreEn && retention |=> !useBackup;
  endproperty
  a_retentionMain: assert property (p_retentionMain) else $error("backup in retention");
  property p_chargerCode;
    coreEn && chargerCfg_reg[7:4] != rtc_ctrl_pkg::CHARGER_ON_CODE |=> !chargerOn;
  endproperty
  a_chargerCode: assert property (p_chargerCode) else $error("charger on bad code");
  property p_alarmOnTick;
    coreEn && !secondTick |=> !$rose(eventFlags_reg[rtc_ctrl_pkg::FLAG_FIRST_ALARM]);
  endproperty
  a_alarmOnTick: assert property (p_alarmOnTick) else $error("alarm off tick");
  property p_secondAlarmZero;
    coreEn && timeNow.sec != 8'h00 |=> !$rose(eventFlags_reg[rtc_ctrl_pkg::FLAG_SECOND_ALARM]);
  endproperty
  a_secondAlarmZero: assert property (p_secondAlarmZero) else $error("alarm2 off zero");
endmodule : rtc_ctrl

/* hw/rtc_ctrl_pkg.sv */
// Shared constants and carrier types of the clock control block.
package rtc_ctrl_pkg;
  // Register offsets.
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h01;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h02;
  localparam logic [7:0] ADDR_RETENTION_CFG = 8'h03;
  localparam logic [7:0] ADDR_COUNTDOWN_CFG = 8'h05;
  localparam logic [7:0] ADDR_ALARM_FIRST = 8'h0D;
  localparam logic [7:0] ADDR_ALARM_LAST = 8'h15;
  localparam logic [7:0] ADDR_COUNTDOWN_NOW = 8'h16;
  localparam logic [7:0] ADDR_COUNTDOWN_START = 8'h17;
  localparam logic [7:0] ADDR_SUPPLY_MGMT = 8'h18;
  localparam logic [7:0] ADDR_CHARGER_CFG = 8'h19;
  localparam logic [7:0] ADDR_THERMAL_CFG = 8'h1C;
  // Alarm byte indices relative to ADDR_ALARM_FIRST.
  localparam int A1_SEC = 0;
  localparam int A1_MIN = 1;
  localparam int A1_HOUR = 2;
  localparam int A1_DAY = 3;
  localparam int A1_MONTH = 4;
  localparam int A1_YEAR = 5;
  localparam int A2_MIN = 6;
  localparam int A2_HOUR = 7;
  localparam int A2_DAY = 8;
  localparam int ALARM_BYTES = 9;
  // Field positions.
  localparam int BIT_MASK = 7;
  localparam int BIT_DAY_SELECT = 6;
  localparam int BIT_YEAR_MASK = 6;
  localparam int FLAG_FIRST_ALARM = 0;
  localparam int FLAG_SECOND_ALARM = 1;
  localparam int FLAG_COUNTDOWN = 2;
  localparam int FLAG_THERMAL = 3;
  localparam int FLAG_SUPPLY_DROP = 5;
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_OSC_ENABLE = 1;
  localparam int BIT_RETENTION = 4;
  localparam int BIT_COUNTDOWN_RUN = 4;
  localparam int BIT_COUNTDOWN_HOLD = 3;
  localparam int BIT_COUNTDOWN_RELOAD = 2;
  localparam int BIT_MANUAL_SUPPLY = 2;
  localparam int BIT_BACKUP_SOURCE = 3;
  localparam int BIT_PERIODIC_CONV = 7;
  localparam int BIT_SINGLE_CONV = 6;
  // Field values and reset values.
  localparam logic [3:0] CHARGER_ON_CODE = 4'h5;
  localparam logic [7:0] EVENT_FLAGS_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] RETENTION_CFG_RESET = 8'h02;
  localparam logic [7:0] COUNTDOWN_CFG_RESET = 8'h00;
  localparam logic [7:0] SUPPLY_MGMT_RESET = 8'h10;
  localparam logic [7:0] CHARGER_CFG_RESET = 8'h00;
  localparam logic [7:0] THERMAL_CFG_RESET = 8'h80;
  localparam logic [7:0] ALARM_RESET = 8'h00;
  // Timing.
  localparam int CORE_CLK_MHZ = 200;
  localparam int CONV_TIME_MS = 70;
  localparam int CONV_CYCLES = CONV_TIME_MS * 1000 * CORE_CLK_MHZ;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } rtc_time_type;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtc_req_type;
endpackage : rtc_ctrl_pkg

/* test/rtc_host_model.sv */
// Host-side register link master used by the bench.
`timescale 1ns/1ps
module rtc_host_model (
  input wire logic linkClk,
  input wire logic regBusy,
  input wire logic regAck,
  input wire logic [7:0] regRdata,
  output logic regReq,
  output rtc_ctrl_pkg::rtc_req_type regCmd
);
  initial begin
    regReq = 1'b0;
    regCmd = '0;
  end
  // Stale command fields are inverted so the block cannot lean on an idle bus.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    int n;
    ok = 1'b0;
    @(negedge linkClk);
    regReq = 1'b1;
    regCmd = '{w, a, d};
    @(negedge linkClk);
    regReq = 1'b0;
    regCmd = ~regCmd;
    // A request that did not raise busy was never taken, so it runs out as a failure.
    for (n = (regBusy === 1'b1) ? 0 : 60; n < 60 && !ok; n++) begin
      @(negedge linkClk);
      if (regAck === 1'b1) begin
        q = regRdata;
        ok = 1'b1;
      end
    end
  endtask : access
endmodule : rtc_host_model

/* test/rtc_ctrl_bench.sv */
// Self-checking bench of the clock control block.
`timescale 1ns/1ps
module rtc_ctrl_bench;
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic reset_n = 1'b0;
  logic secondTick = 1'b0;
  logic [3:0] countdownTicks = 4'h0;
  rtc_ctrl_pkg::rtc_time_type timeNow = '0;
  logic vccBelowThreshold = 1'b0;
  logic vccBelowBackup = 1'b0;
  logic regReq, regBusy, regAck, intOut_n, useBackup, chargerOn, oscStop, convStart, softRst;
  logic [7:0] regRdata;
  logic [1:0] thr;
  rtc_ctrl_pkg::rtc_req_type regCmd;
  int n_fail = 0;
  int num_checks = 0;
  int nConv = 0;
  int nSoft = 0;
  always #2.5 core_clk = ~core_clk;
  always #24 linkClk = ~linkClk;
  always @(posedge core_clk) if (convStart === 1'b1) nConv++;
  always @(posedge core_clk) if (softRst === 1'b1) nSoft++;
  rtc_ctrl #(.CONV_CYCLES(20)) i_rtc_ctrl (.core_clk(core_clk), .reset_n(reset_n),
    .coreEn(1'b1), .secondTick(secondTick), .countdownTicks(countdownTicks),
    .timeNow(timeNow), .vccBelowThreshold(vccBelowThreshold),
    .vccBelowBackup(vccBelowBackup), .linkClk(linkClk), .regReq(regReq), .regCmd(regCmd),
    .regBusy(regBusy), .regAck(regAck), .regRdata(regRdata), .intOut_n(intOut_n),
    .useBackup(useBackup), .chargerOn(chargerOn), .supplyThresholdSelect(thr),
    .oscStop(oscStop), .convStart(convStart), .softResetPulse(softRst));
  rtc_host_model i_rtc_host_model (.linkClk(linkClk), .regBusy(regBusy), .regAck(regAck),
    .regRdata(regRdata), .regReq(regReq), .regCmd(regCmd));
  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic ok;
    i_rtc_host_model.access(w, a, d, q, ok);
    if (!ok) begin
      n_fail++;
      end_sim();
    end
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd
  task automatic tick(input logic [7:0] s);
    @(negedge core_clk);
    timeNow.sec = s;
    secondTick = 1'b1;
    @(negedge core_clk);
    secondTick = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : tick
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge core_clk);
      countdownTicks = 4'h1;
      @(negedge core_clk);
      countdownTicks = 4'h0;
    end
  endtask : pulse
  task automatic t_reset;
    rd(8'h18, 8'h10);
    rd(8'h1F, 8'h00);
    wr(8'h18, 8'h20);
    chk("threshold", 8'h02, {6'h00, thr});
    wr(8'h18, 8'h10);
  endtask : t_reset
  task automatic t_alarm1;
    wr(8'h01, 8'h00);
    for (int i = 0; i < 4; i++) wr(8'h0D + 8'(i), 8'h80);
    wr(8'h11, 8'hC0);
    tick(8'h01);
    wr(8'h01, 8'h01);
    tick(8'h05);
    chk("intOut_n", 8'h00, {7'h00, intOut_n});
    rd(8'h00, 8'h01);
    chk("intOut_n", 8'h01, {7'h00, intOut_n});
    rd(8'h00, 8'h00);
    wr(8'h0D, 8'h30);
    tick(8'h29);
    rd(8'h00, 8'h00);
    tick(8'h30);
    rd(8'h00, 8'h01);
  endtask : t_alarm1
  task automatic t_alarm2;
    wr(8'h01, 8'h02);
    for (int i = 0; i < 3; i++) wr(8'h13 + 8'(i), 8'h80);
    tick(8'h30);
    rd(8'h00, 8'h00);
    tick(8'h00);
    rd(8'h00, 8'h02);
    wr(8'h01, 8'h00);
    wr(8'h15, 8'h45);
    tick(8'h00);
    wr(8'h01, 8'h02);
    tick(8'h00);
    rd(8'h00, 8'h00);
    @(negedge core_clk);
    timeNow.date = 8'h05;
    tick(8'h00);
    rd(8'h00, 8'h02);
    wr(8'h01, 8'h00);
    wr(8'h15, 8'h05);
    tick(8'h00);
    wr(8'h01, 8'h02);
    tick(8'h00);
    rd(8'h00, 8'h00);
  endtask : t_alarm2
  task automatic t_countdown;
    wr(8'h01, 8'h04);
    wr(8'h17, 8'h03);
    wr(8'h05, 8'h10);
    pulse(1);
    wr(8'h05, 8'h18);
    pulse(2);
    rd(8'h16, 8'h02);
    wr(8'h05, 8'h10);
    pulse(2);
    chk("intOut_n", 8'h00, {7'h00, intOut_n});
    rd(8'h00, 8'h04);
    wr(8'h05, 8'h00);
    wr(8'h05, 8'h14);
    pulse(3);
    rd(8'h16, 8'h03);
    rd(8'h00, 8'h04);
    wr(8'h05, 8'h00);
  endtask : t_countdown
  task automatic t_conv;
    int c;
    chk("periodic", 8'h01, {7'h00, nConv > 0});
    c = nConv;
    wr(8'h1C, 8'h40);
    chk("conv count", 8'h01, 8'(nConv - c));
    rd(8'h1C, 8'h00);
  endtask : t_conv
  task automatic t_supply;
    wr(8'h01, 8'h20);
    @(negedge core_clk);
    vccBelowThreshold = 1'b1;
    vccBelowBackup = 1'b1;
    repeat (12) @(negedge core_clk);
    chk("useBackup", 8'h01, {7'h00, useBackup});
    rd(8'h00, 8'h20);
    wr(8'h19, 8'h50);
    chk("chargerOn", 8'h01, {7'h00, chargerOn});
    wr(8'h19, 8'h40);
    chk("chargerOn", 8'h00, {7'h00, chargerOn});
    wr(8'h18, 8'h14);
    chk("useBackup", 8'h00, {7'h00, useBackup});
    wr(8'h18, 8'h1C);
    chk("useBackup", 8'h01, {7'h00, useBackup});
    wr(8'h03, 8'h12);
    chk("useBackup", 8'h00, {7'h00, useBackup});
    chk("oscStop", 8'h01, {7'h00, oscStop});
    wr(8'h03, 8'h02);
    chk("oscStop", 8'h00, {7'h00, oscStop});
    chk("useBackup", 8'h01, {7'h00, useBackup});
    wr(8'h02, 8'h01);
    chk("softRst", 8'h01, 8'(nSoft));
    rd(8'h18, 8'h10);
  endtask : t_supply
  initial begin
    repeat (4) @(negedge linkClk);
    @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge linkClk);
    t_reset();
    t_alarm1();
    t_alarm2();
    t_countdown();
    t_conv();
    t_supply();
    end_sim();
  end
endmodule : rtc_ctrl_bench
